// ===== include/card_pkg.sv
package card_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int CSR_W = 16;
   localparam int ID_W = 16;
   localparam int VEC_W = 8;
   localparam int BIT_IDX_W = 4;
   localparam int BIT_IDX_LSB = 2;

   localparam logic [ADDR_W-1:0] CSR_BASE = 20'h10000;
   localparam logic [ADDR_W-1:0] CSR_BIT_LAST = 20'h1003C;
   localparam logic [ADDR_W-1:0] CSR_END = 20'h1004B;
   localparam logic [ADDR_W-1:0] FLUSH_ALL_ADDR = 20'h10044;
   localparam logic [ADDR_W-1:0] FLUSH_DATA_ADDR = 20'h10048;
   localparam logic [ADDR_W-1:0] ID_ADDR = 20'h14000;
   localparam logic [1:0] WORD_ALIGNED = 2'h0;

   localparam int BIT_RESET = 0;
   localparam int BIT_HALT = 1;
   localparam int BIT_HOST_IRQ = 2;
   localparam int BIT_ERROR = 3;
   localparam int BIT_ALIGN = 11;
   localparam int BIT_LOCAL_IRQ = 13;
   localparam int BIT_CACHE_OFF = 14;

   localparam logic [CSR_W-1:0] CSR_SW_MASK = 16'h680F;
   localparam logic [CSR_W-1:0] RSVD_HI_MASK = 16'h9000;
   localparam logic [CSR_W-1:0] RSVD_BUS_MASK = 16'h07F0;
   localparam logic [CSR_W-1:0] CSR_RESET = 16'h4002;
   localparam logic [VEC_W-1:0] ID_FILL = 8'h00;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_ANSWER = 2'b10
   } bus_state_t;
endpackage : card_pkg

// ===== include/csr_access_if.sv
interface csr_access_if;
   logic [card_pkg::CSR_W-1:0] bit_we;
   logic bit_val;
   logic flush_all;
   logic flush_data;
   logic csr_rd;
   logic id_rd;
   logic answer;

   modport decoder (output bit_we, output bit_val, output flush_all, output flush_data,
                    output csr_rd, output id_rd, output answer);
   modport core (input bit_we, input bit_val, input flush_all, input flush_data,
                 input csr_rd, input id_rd, input answer);
endinterface : csr_access_if

// ===== logic/card_bus_decode.sv
module card_bus_decode
   import card_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic bus_req_i,
   input wire logic bus_wr_i,
   input wire logic [ADDR_W-1:0] bus_addr_i,
   input wire logic bus_wbit_i,
   csr_access_if.decoder acc
);
   bus_state_t state_reg;
   bus_state_t state_next;
   logic take;
   logic in_bit_window;
   logic in_csr_window;
   logic [BIT_IDX_W-1:0] bit_idx;

   // one request per answer: a request seen while answering is dropped
   assign take = bus_req_i && (state_reg == ST_IDLE);
   assign in_bit_window = (bus_addr_i >= CSR_BASE) && (bus_addr_i <= CSR_BIT_LAST)
                          && (bus_addr_i[1:0] == WORD_ALIGNED);
   assign in_csr_window = (bus_addr_i >= CSR_BASE) && (bus_addr_i <= CSR_END);
   assign bit_idx = bus_addr_i[BIT_IDX_LSB +: BIT_IDX_W];

   always_comb
   begin
      state_next = state_reg;
      acc.bit_we = '0;
      acc.bit_val = bus_wbit_i;
      acc.flush_all = 1'b0;
      acc.flush_data = 1'b0;
      acc.csr_rd = 1'b0;
      acc.id_rd = 1'b0;
      unique case (state_reg)
         ST_IDLE:
         begin
            if (take)
            begin
               state_next = ST_ANSWER;
               // each write address carries exactly one control bit
               if (bus_wr_i && in_bit_window)
               begin
                  acc.bit_we = CSR_W'(1) << bit_idx; // R2
               end
               acc.flush_all = (bus_addr_i == FLUSH_ALL_ADDR); // R5
               acc.flush_data = (bus_addr_i == FLUSH_DATA_ADDR); // R5
               acc.csr_rd = !bus_wr_i && in_csr_window;
               acc.id_rd = !bus_wr_i && (bus_addr_i == ID_ADDR);
            end
         end
         ST_ANSWER:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_reg <= ST_IDLE;
      end
      else if (ce_i)
      begin
         state_reg <= state_next;
      end
   end

   assign acc.answer = (state_reg == ST_ANSWER);

   property p_flush_decode;
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && take && (bus_addr_i == FLUSH_ALL_ADDR) |-> acc.flush_all && !acc.flush_data;
   endproperty
   a_flush_decode: assert property (p_flush_decode) // R5
      else $error("flush-all access did not raise only the full flush");
endmodule : card_bus_decode

// ===== logic/coprocessor_card_control_status.sv
// Functional notes
// (R1) csr is 16 bits, read back on a 32-bit transfer, upper half undefined.
// (R2) a csr write changes only the one bit selected by its address.
// (R3) bits 15 and 12 read zero and ignore writes.
// (R4) bit 14 turns the virtual cache off; powerup reset sets it.
// (R5) access at 0x10044 flushes whole cache, at 0x10048 only data part.
// (R6) bit 13 is software-only and drives the local level 15 interrupt.
// (R7) bit 11 is set by an alignment fault and held until software clears.
// (R8) bits 4 to 10 are reserved and always read zero.
// (R9) bit 3 is set only by a bus fault during a main-memory access; a software write of 1 to 0x1000C also sets it.
// (R10) that same bus fault also raises a memory exception to the processor.
// (R11) bit 2 drives the level 15 interrupt to the host; powerup clears it.
// (R12) halt bit is set on every card reset; processor idles until cleared.
// (R13) setting halt stops the card synchronously; clearing resumes where it stopped.
// (R14) writing bit 0 resets the card; board bus reset clears it.
// (R15) card_id_vector shows id low byte first, then an 8-bit interrupt vector.
// (R16) host polls each slot's card_id_vector during self-configuration.
// (R17) no self-generated bus error can set the error flag.
// (R18) interrupt outputs follow their bits and drop the cycle after a clear.
module coprocessor_card_control_status
   import card_pkg::*;
#(
   // arbitrary value, stands in for the card's id low byte
   parameter logic [VEC_W-1:0] ID_LOW_BYTE = 8'h5A
)
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic bus_req_i,
   input wire logic bus_wr_i,
   input wire logic [ADDR_W-1:0] bus_addr_i,
   input wire logic [DATA_W-1:0] bus_wdata_i,
   output logic [DATA_W-1:0] bus_rdata_o,
   output logic bus_ack_o,
   input wire logic board_bus_reset_i,
   input wire logic alignment_fault_i,
   input wire logic mem_bus_fault_i,
   input wire logic mem_access_i,
   input wire logic vector_load_i,
   input wire logic [VEC_W-1:0] vector_i,
   output logic cache_disable_o,
   output logic cache_flush_all_o,
   output logic cache_flush_data_o,
   output logic local_level15_irq_request_o,
   output logic host_level15_irq_request_o,
   output logic mem_exception_o,
   output logic cpu_halt_o,
   output logic card_reset_o
);
   csr_access_if acc ();

   logic brst_meta_reg;
   logic brst_meta_next;
   logic brst_sync_reg;
   logic brst_sync_next;
   logic [CSR_W-1:0] csr_reg;
   logic [CSR_W-1:0] csr_next;
   logic [CSR_W-1:0] hw_set;
   logic [CSR_W-1:0] hw_clr;
   logic [ID_W-1:0] id_reg;
   logic [ID_W-1:0] id_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic flush_all_reg;
   logic flush_all_next;
   logic flush_data_reg;
   logic flush_data_next;
   logic mem_exc_reg;
   logic mem_exc_next;
   logic mem_fault_hit;

   card_bus_decode u_decode
   (
      .clk_i (clk_i),
      .rstn_i (rstn_i),
      .ce_i (ce_i),
      .bus_req_i (bus_req_i),
      .bus_wr_i (bus_wr_i),
      .bus_addr_i (bus_addr_i),
      .bus_wbit_i (bus_wdata_i[0]),
      .acc (acc)
   );

   // board bus reset arrives from another board: two stages before use
   always_comb
   begin
      brst_meta_next = board_bus_reset_i;
      brst_sync_next = brst_meta_reg;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         brst_meta_reg <= 1'b0;
         brst_sync_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         brst_meta_reg <= brst_meta_next;
         brst_sync_reg <= brst_sync_next;
      end
   end

   // only a fault seen while the card itself reaches main memory counts;
   // the card never drives the fault or fail lines, so apart from a software write nothing else sets it
   assign mem_fault_hit = mem_bus_fault_i && mem_access_i; // R17

   always_comb
   begin
      hw_set = '0;
      hw_clr = '0;
      hw_set[BIT_ALIGN] = alignment_fault_i; // R7
      hw_set[BIT_ERROR] = mem_fault_hit; // R9
      // a pending card reset or a board reset both hold the processor halted
      hw_set[BIT_HALT] = csr_reg[BIT_RESET] || brst_sync_reg; // R12
      hw_clr[BIT_RESET] = brst_sync_reg; // R14
   end

   // hardware set beats a software clear in the same cycle, so no event is lost
   for (genvar i = 0; i < CSR_W; i++)
   begin : g_csr_bit
      if (CSR_SW_MASK[i])
      begin : g_live
         assign csr_next[i] = hw_set[i] || (!hw_clr[i] && (acc.bit_we[i] ? acc.bit_val : csr_reg[i])); // R2
      end
      else
      begin : g_rsvd
         assign csr_next[i] = 1'b0; // R3 R8
      end
   end

   always_comb
   begin
      id_next = id_reg;
      if (vector_load_i)
      begin
         id_next = {ID_FILL, vector_i}; // R15
      end
      // upper half of the word is undefined; driven as zero to keep it stable
      rdata_next = '0;
      if (acc.csr_rd)
      begin
         rdata_next = {{(DATA_W-CSR_W){1'b0}}, csr_reg}; // R1
      end
      else if (acc.id_rd)
      begin
         rdata_next = {{(DATA_W-ID_W){1'b0}}, id_reg}; // R15
      end
      flush_all_next = acc.flush_all; // R5
      flush_data_next = acc.flush_data; // R5
      mem_exc_next = mem_fault_hit; // R10
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         csr_reg <= CSR_RESET; // R4
         id_reg <= {ID_FILL, ID_LOW_BYTE};
         rdata_reg <= '0;
         flush_all_reg <= 1'b0;
         flush_data_reg <= 1'b0;
         mem_exc_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         csr_reg <= csr_next;
         id_reg <= id_next;
         rdata_reg <= rdata_next;
         flush_all_reg <= flush_all_next;
         flush_data_reg <= flush_data_next;
         mem_exc_reg <= mem_exc_next;
      end
   end

   assign bus_rdata_o = rdata_reg;
   assign bus_ack_o = acc.answer;
   assign cache_disable_o = csr_reg[BIT_CACHE_OFF]; // R4
   assign cache_flush_all_o = flush_all_reg;
   assign cache_flush_data_o = flush_data_reg;
   assign local_level15_irq_request_o = csr_reg[BIT_LOCAL_IRQ]; // R6 R18
   assign host_level15_irq_request_o = csr_reg[BIT_HOST_IRQ]; // R11 R18
   assign mem_exception_o = mem_exc_reg;
   // halt is a level the processor samples at instruction boundaries, which
   // is what makes the stop synchronous and the resume exact
   assign cpu_halt_o = csr_reg[BIT_HALT]; // R13
   assign card_reset_o = csr_reg[BIT_RESET]; // R14

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   property p_csr_read;
      ce_i && acc.csr_rd |=> bus_ack_o && (bus_rdata_o[CSR_W-1:0] == $past(csr_reg));
   endproperty
   a_csr_read: assert property (p_csr_read) // R1
      else $error("csr read did not return the register on the answer cycle");

   property p_single_bit;
      ce_i && (acc.bit_we != '0) && !alignment_fault_i && !mem_fault_hit && !brst_sync_reg
         && !csr_reg[BIT_RESET] |=> ((csr_reg ^ $past(csr_reg)) & ~$past(acc.bit_we)) == '0;
   endproperty
   a_single_bit: assert property (p_single_bit) // R2
      else $error("csr write disturbed a bit other than the addressed one");

   property p_rsvd_hi;
      (csr_reg & RSVD_HI_MASK) == '0;
   endproperty
   a_rsvd_hi: assert property (p_rsvd_hi) // R3
      else $error("bit 15 or 12 of the csr is not zero");

   property p_cache_off;
      ce_i && acc.bit_we[BIT_CACHE_OFF] |=> cache_disable_o == $past(acc.bit_val);
   endproperty
   a_cache_off: assert property (p_cache_off) // R4
      else $error("cache disable did not follow its write");

   property p_flush_pulse;
      ce_i && acc.flush_data |=> cache_flush_data_o && !cache_flush_all_o;
   endproperty
   a_flush_pulse: assert property (p_flush_pulse) // R5
      else $error("data flush access did not pulse the data flush");

   property p_local_irq;
      ce_i && acc.bit_we[BIT_LOCAL_IRQ] |=> local_level15_irq_request_o == $past(acc.bit_val);
   endproperty
   a_local_irq: assert property (p_local_irq) // R6
      else $error("local interrupt request did not follow its bit");

   property p_align_sticky;
      ce_i && alignment_fault_i |=> csr_reg[BIT_ALIGN];
   endproperty
   a_align_sticky: assert property (p_align_sticky) // R7
      else $error("alignment fault did not set its flag");

   property p_rsvd_bus;
      ce_i && acc.csr_rd |=> (bus_rdata_o & DATA_W'(RSVD_BUS_MASK)) == '0;
   endproperty
   a_rsvd_bus: assert property (p_rsvd_bus) // R8
      else $error("reserved csr bits 4 to 10 read back nonzero");

   property p_error_set;
      ce_i && mem_bus_fault_i && mem_access_i |=> csr_reg[BIT_ERROR];
   endproperty
   a_error_set: assert property (p_error_set) // R9
      else $error("main-memory bus fault did not set the error flag");

   property p_error_cause;
      $rose(csr_reg[BIT_ERROR]) |-> $past(mem_fault_hit || (acc.bit_we[BIT_ERROR] && acc.bit_val));
   endproperty
   a_error_cause: assert property (p_error_cause) // R17
      else $error("error flag set without a memory bus fault or a write");

   property p_mem_exc;
      ce_i && mem_fault_hit |=> mem_exception_o ##0 csr_reg[BIT_ERROR];
   endproperty
   a_mem_exc: assert property (p_mem_exc) // R10
      else $error("memory bus fault raised no memory exception");

   property p_host_irq;
      ce_i && acc.bit_we[BIT_HOST_IRQ] |=> host_level15_irq_request_o == $past(acc.bit_val);
   endproperty
   a_host_irq: assert property (p_host_irq) // R11
      else $error("host interrupt request did not follow its bit");

   property p_halt_on_reset;
      ce_i && (card_reset_o || brst_sync_reg) |=> cpu_halt_o;
   endproperty
   a_halt_on_reset: assert property (p_halt_on_reset) // R12
      else $error("card reset did not set halt");

   property p_halt_hold;
      ce_i && cpu_halt_o && !acc.bit_we[BIT_HALT] |=> cpu_halt_o;
   endproperty
   a_halt_hold: assert property (p_halt_hold) // R13
      else $error("halt dropped without a software clear");

   property p_board_reset_clears;
      ce_i && brst_sync_reg |=> !card_reset_o;
   endproperty
   a_board_reset_clears: assert property (p_board_reset_clears) // R14
      else $error("board bus reset did not clear the card reset bit");

   property p_id_vector;
      ce_i && vector_load_i |=> id_reg == {ID_FILL, $past(vector_i)};
   endproperty
   a_id_vector: assert property (p_id_vector) // R15
      else $error("interrupt vector not taken into the card_id_vector");

   property p_irq_drop;
      ce_i && acc.bit_we[BIT_HOST_IRQ] && !acc.bit_val |=> !host_level15_irq_request_o;
   endproperty
   a_irq_drop: assert property (p_irq_drop) // R18
      else $error("host interrupt still asserted after its bit was cleared");

   c_halt_release: cover property (ce_i && cpu_halt_o && acc.bit_we[BIT_HALT] && !acc.bit_val
                                   && !card_reset_o && !brst_sync_reg ##1 !cpu_halt_o);
   c_fault_then_clear: cover property (csr_reg[BIT_ERROR] ##[1:20] !csr_reg[BIT_ERROR]);
   c_id_read: cover property (ce_i && acc.id_rd ##1 bus_ack_o);
   c_flush_all: cover property (cache_flush_all_o);
endmodule : coprocessor_card_control_status

// ===== sim/host_bus_model.sv
module host_bus_model
   import card_pkg::*;
(
   input wire logic clk_i,
   input wire logic bus_ack_i,
   input wire logic [DATA_W-1:0] bus_rdata_i,
   output logic bus_req_o,
   output logic bus_wr_o,
   output logic [ADDR_W-1:0] bus_addr_o,
   output logic [DATA_W-1:0] bus_wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      bus_req_o = 1'h0;
      bus_wr_o = 1'h0;
      bus_addr_o = '0;
      bus_wdata_o = '0;
   end

   task automatic access(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdata,
                         output logic [DATA_W-1:0] rdata, output logic acked);
      int n;
      rdata = 'x;
      acked = 1'h0;
      @(posedge clk_i);
      #1;
      bus_req_o = 1'h1;
      bus_wr_o = wr;
      bus_addr_o = addr;
      bus_wdata_o = wdata;
      // held through the answer edge: the decoder ignores a request while it answers
      for (n = 0; n < 4 && acked !== 1'h1; n++)
      begin
         @(posedge clk_i);
         acked = bus_ack_i;
         rdata = bus_rdata_i;
      end
      #1;
      bus_req_o = 1'h0;
      // released lines must not keep showing the old value
      bus_wr_o = ~bus_wr_o;
      bus_addr_o = ~bus_addr_o;
      bus_wdata_o = ~bus_wdata_o;
   endtask : access
endmodule : host_bus_model

// ===== sim/coprocessor_card_control_status_tb.sv
module coprocessor_card_control_status_tb
   import card_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TIMEOUT_CYCLES = 2000;
   // arbitrary id byte, differs from the default so the parameter is seen to arrive
   localparam logic [VEC_W-1:0] ID_BYTE = 8'h3C;

   typedef struct packed
   {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic wbit;
      logic [CSR_W-1:0] rd;
      logic [3:0] outs;
   } row_t;

   logic clk_i = 1'h0;
   logic rstn_i = 1'h0;
   logic ce_i = 1'h1;
   logic bus_req_i, bus_wr_i, bus_ack_o;
   logic [ADDR_W-1:0] bus_addr_i;
   logic [DATA_W-1:0] bus_wdata_i, bus_rdata_o;
   logic board_bus_reset_i = 1'h0;
   logic alignment_fault_i = 1'h0;
   logic mem_bus_fault_i = 1'h0;
   logic mem_access_i = 1'h0;
   logic vector_load_i = 1'h0;
   logic [VEC_W-1:0] vector_i = 8'h00;
   logic cache_disable_o, cache_flush_all_o, cache_flush_data_o, local_level15_irq_request_o;
   logic host_level15_irq_request_o, mem_exception_o, cpu_halt_o, card_reset_o;
   wire logic [3:0] outs = {cache_disable_o, local_level15_irq_request_o, host_level15_irq_request_o, cpu_halt_o};
   int failures = 0;
   int n_tests = 0;
   int n_fa = 0;
   int n_fd = 0;
   int n_exc = 0;

   // each row: one access, then the read word (reads only) and the four control levels
   row_t rows [15] = '{
      '{1'h0, 20'h10000, 1'h0, 16'h4002, 4'h9}, '{1'h1, 20'h10034, 1'h1, 16'h0000, 4'hD},
      '{1'h1, 20'h10008, 1'h1, 16'h0000, 4'hF}, '{1'h1, 20'h1003C, 1'h1, 16'h0000, 4'hF},
      '{1'h1, 20'h10030, 1'h1, 16'h0000, 4'hF}, '{1'h1, 20'h10010, 1'h1, 16'h0000, 4'hF},
      '{1'h0, 20'h10000, 1'h0, 16'h6006, 4'hF}, '{1'h1, 20'h10038, 1'h0, 16'h0000, 4'h7},
      '{1'h1, 20'h10004, 1'h0, 16'h0000, 4'h6}, '{1'h0, 20'h10000, 1'h0, 16'h2004, 4'h6},
      '{1'h1, 20'h10034, 1'h0, 16'h0000, 4'h2}, '{1'h1, 20'h10008, 1'h0, 16'h0000, 4'h0},
      '{1'h0, 20'h10020, 1'h0, 16'h0000, 4'h0}, '{1'h0, 20'h14000, 1'h0, 16'h003C, 4'h0},
      '{1'h0, 20'h20000, 1'h0, 16'h0000, 4'h0}};

   always #25 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      n_fa += int'(cache_flush_all_o === 1'h1);
      n_fd += int'(cache_flush_data_o === 1'h1);
      n_exc += int'(mem_exception_o === 1'h1);
   end

   coprocessor_card_control_status #(.ID_LOW_BYTE(ID_BYTE)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .bus_req_i(bus_req_i), .bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
      .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o), .board_bus_reset_i(board_bus_reset_i),
      .alignment_fault_i(alignment_fault_i), .mem_bus_fault_i(mem_bus_fault_i), .mem_access_i(mem_access_i),
      .vector_load_i(vector_load_i), .vector_i(vector_i), .cache_disable_o(cache_disable_o),
      .cache_flush_all_o(cache_flush_all_o), .cache_flush_data_o(cache_flush_data_o),
      .local_level15_irq_request_o(local_level15_irq_request_o),
      .host_level15_irq_request_o(host_level15_irq_request_o), .mem_exception_o(mem_exception_o),
      .cpu_halt_o(cpu_halt_o), .card_reset_o(card_reset_o));

   host_bus_model host (.clk_i(clk_i), .bus_ack_i(bus_ack_o), .bus_rdata_i(bus_rdata_o), .bus_req_o(bus_req_i),
      .bus_wr_o(bus_wr_i), .bus_addr_o(bus_addr_i), .bus_wdata_o(bus_wdata_i));

   task automatic check_word(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic bus(input logic wr, input logic [ADDR_W-1:0] addr, input logic d, output logic [DATA_W-1:0] rd);
      logic ok;
      host.access(wr, addr, {31'h0, d}, rd, ok);
      check_word("bus answer", 32'h1, {31'h0, ok});
   endtask : bus

   task automatic hw_pulse(input logic [3:0] sel);
      @(posedge clk_i);
      #1;
      {alignment_fault_i, mem_bus_fault_i, mem_access_i, vector_load_i} = sel;
      @(posedge clk_i);
      #1;
      {alignment_fault_i, mem_bus_fault_i, mem_access_i, vector_load_i} = 4'h0;
   endtask : hw_pulse

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (TIMEOUT_CYCLES) @(posedge clk_i);
      failures++;
      $display("unexpected watchdog: expected finish, seen timeout");
      end_of_test();
   end

   initial
   begin
      logic [DATA_W-1:0] rd;
      int fa;
      int fd;
      repeat (6) @(posedge clk_i);
      #1;
      rstn_i = 1'h1;
      foreach (rows[i])
      begin
         bus(rows[i].wr, rows[i].addr, rows[i].wbit, rd);
         if (rows[i].wr == 1'h0)
            check_word("read data", {16'h0, rows[i].rd}, rd);
         check_word("control levels", {28'h0, rows[i].outs}, {28'h0, outs});
      end
      $display("register rows done");
      fa = n_fa;
      fd = n_fd;
      bus(1'h0, FLUSH_ALL_ADDR, 1'h0, rd);
      bus(1'h1, FLUSH_DATA_ADDR, 1'h0, rd);
      bus(1'h1, FLUSH_ALL_ADDR, 1'h1, rd);
      check_word("flush all pulses", 32'h2, 32'(n_fa - fa));
      check_word("flush data pulses", 32'h1, 32'(n_fd - fd));
      $display("flush done");
      // a fault outside a memory access, and an access without fault, must leave the flags alone
      hw_pulse(4'h4);
      hw_pulse(4'h2);
      bus(1'h0, CSR_BASE, 1'h0, rd);
      check_word("csr after stray fault", 32'h0, rd);
      check_word("exceptions", 32'h0, 32'(n_exc));
      hw_pulse(4'hE);
      bus(1'h0, CSR_BASE, 1'h0, rd);
      check_word("csr after faults", 32'h0808, rd);
      check_word("exceptions", 32'h1, 32'(n_exc));
      bus(1'h1, 20'h1002C, 1'h0, rd);
      bus(1'h1, 20'h1000C, 1'h0, rd);
      bus(1'h0, CSR_BASE, 1'h0, rd);
      check_word("csr after clears", 32'h0, rd);
      // with the clock enable low a fault must not be captured
      ce_i = 1'h0;
      hw_pulse(4'hE);
      ce_i = 1'h1;
      bus(1'h0, CSR_BASE, 1'h0, rd);
      check_word("csr with clock held", 32'h0, rd);
      check_word("exceptions", 32'h1, 32'(n_exc));
      $display("fault flags done");
      vector_i = 8'hA7;
      hw_pulse(4'h1);
      bus(1'h0, ID_ADDR, 1'h0, rd);
      check_word("vector", 32'h00A7, rd);
      $display("vector done");
      bus(1'h1, CSR_BASE, 1'h1, rd);
      check_word("card reset, halt", 32'h3, {30'h0, card_reset_o, cpu_halt_o});
      board_bus_reset_i = 1'h1;
      repeat (4) @(posedge clk_i);
      #1;
      board_bus_reset_i = 1'h0;
      repeat (3) @(posedge clk_i);
      #1;
      check_word("card reset, halt", 32'h1, {30'h0, card_reset_o, cpu_halt_o});
      bus(1'h1, 20'h10004, 1'h0, rd);
      check_word("halt cleared", 32'h0, {31'h0, cpu_halt_o});
      bus(1'h1, 20'h10004, 1'h1, rd);
      check_word("halt set", 32'h1, {31'h0, cpu_halt_o});
      $display("card reset and halt done");
      bus(1'h1, 20'h10008, 1'h1, rd);
      bus(1'h1, 20'h10038, 1'h0, rd);
      check_word("levels before reset", 32'h3, {28'h0, outs});
      rstn_i = 1'h0;
      repeat (2) @(posedge clk_i);
      #1;
      rstn_i = 1'h1;
      repeat (2) @(posedge clk_i);
      #1;
      check_word("levels after reset", 32'h9, {28'h0, outs});
      $display("second reset done");
      end_of_test();
   end
endmodule : coprocessor_card_control_status_tb
